// ### rtl/scdt_decode_trap.sv
`timescale 1ns/1ps
`include "scdt_defs.svh"
// Contract
// - supervisor call saves next word address
// - flag-setting return restores pc and status
// - low 24 bits of call ignored
// - supervisor call costs three fetch cycles
// - only control coprocessor 15, register transfers
// - other coprocessor instructions take undefined trap
// - passing data operation always traps undefined
// - failed condition: no execution, no trap
// - data operation decodes bit 4, 24-27
// - data operation never waits for result
// - passing load or store traps undefined
// - offset shifted two, added or subtracted
// - pre bit picks offset before use
// - write-back only when write bit set
// - later words four bytes higher each
// - low address bits driven unaligned
// - pc base is instruction address plus 8
// - abort: trap, still write back base
// - supervisor call vectors 0x08, saves status
module scdt_decode_trap #(
  parameter bit          XFER_TRAPS = 1'b1,
  parameter int unsigned SVC_FETCHES = `SCDT_SVC_FETCH,
  parameter logic [31:0] UND_VECTOR = `SCDT_VEC_UND,
  parameter logic [31:0] ABT_VECTOR = `SCDT_VEC_ABT
) (
  input  wire logic                I_CLOCK,
  input  wire logic                I_RST_N,
  input  wire logic                I_INSTR_VALID,
  input  wire logic [31:0]         I_INSTR,
  input  wire logic [31:0]         I_INSTR_ADDR,
  input  wire logic                I_COND_PASS,
  input  wire logic [31:0]         I_BASE_VALUE,
  input  wire logic                I_WORD_ACK,
  input  wire logic                I_XFER_LAST,
  input  wire logic                I_MEM_ABORT,
  output logic                     O_BUSY,
  output logic                     O_FETCH,
  output logic                     O_PC_LOAD,
  output logic [31:0]              O_PC_VALUE,
  output logic [31:0]              O_STATUS,
  output logic [31:0]              O_SVC_LINK,
  output logic [31:0]              O_SVC_SAVED,
  output logic [31:0]              O_UND_LINK,
  output logic [31:0]              O_UND_SAVED,
  output logic                     O_TRAP,
  output scdt_pkg::scdt_trap_t     O_TRAP_KIND,
  output logic                     O_CP_CTRL,
  output logic                     O_ADDR_VALID,
  output logic [31:0]              O_ADDR,
  output logic                     O_BASE_WB,
  output logic [31:0]              O_BASE_WB_VALUE,
  output logic [3:0]               O_BASE_REG
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SVC_FETCHES < 2 || SVC_FETCHES > 7) begin : g_chk_fetch
    $error("SVC_FETCHES must lie in 2..7");
  end

  localparam logic [2:0] LAST_FETCH = 3'(SVC_FETCHES - 1);

  scdt_pkg::scdt_core_t s_r;
  scdt_pkg::scdt_core_t s_nxt;
  scdt_pkg::scdt_xfer_t gen_xfer;

  logic accept;
  logic is_svc;
  logic is_cdo;
  logic is_cxf;
  logic is_crt;
  logic is_ret;
  logic in_svc;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // next word address, used for links and multi-word steps
  function automatic logic [31:0] word_after(input logic [31:0] a);
    word_after = a + `SCDT_WORD_STEP;
  endfunction

  // ----------------------------------------------------------------
  // addressing of coprocessor transfers
  // ----------------------------------------------------------------
  scdt_addr_gen u_addr_gen (
    .i_instr      (I_INSTR),
    .i_instr_addr (I_INSTR_ADDR),
    .i_base_value (I_BASE_VALUE),
    .o_xfer       (gen_xfer)
  );

  // ----------------------------------------------------------------
  // class decode
  // ----------------------------------------------------------------
  // a failed condition accepts nothing
  assign accept = I_INSTR_VALID && !s_r.busy && I_COND_PASS;
  // comment field below bit 24 is never looked at
  assign is_svc = I_INSTR[`SCDT_F_CLS4] == `SCDT_CLS_SVC;
  // data operation: bits 24-27 and bit 4 only
  assign is_cdo = I_INSTR[`SCDT_F_CLS4] == `SCDT_CLS_CDO &&
                  !I_INSTR[`SCDT_B_CPBIT];
  assign is_crt = I_INSTR[`SCDT_F_CLS4] == `SCDT_CLS_CDO &&
                  I_INSTR[`SCDT_B_CPBIT];
  assign is_cxf = I_INSTR[`SCDT_F_CLS3] == `SCDT_CLS_CXF;
  assign in_svc = s_r.status[`SCDT_F_MODE] == `SCDT_MODE_SVC;
  assign is_ret = I_INSTR[`SCDT_F_BODY] == `SCDT_RET_BODY && in_svc;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt            = s_r;
    s_nxt.fetch      = 1'b0;
    s_nxt.pc_load    = 1'b0;
    s_nxt.trap       = 1'b0;
    s_nxt.cp_ctrl    = 1'b0;
    s_nxt.base_wb    = 1'b0;
    unique case (s_r.phase)
      scdt_pkg::PH_IDLE: begin
        if (accept && is_svc) begin
          // single copy of link and saved status
          s_nxt.svc_link  = word_after(I_INSTR_ADDR);
          s_nxt.svc_saved = s_r.status;
          s_nxt.status[`SCDT_F_MODE] = `SCDT_MODE_SVC;
          s_nxt.trap      = 1'b1;
          s_nxt.trap_kind = scdt_pkg::TRAP_SVC;
          s_nxt.fetch     = 1'b1;
          s_nxt.cnt       = 3'h1;
          s_nxt.busy      = 1'b1;
          s_nxt.phase     = scdt_pkg::PH_SVC;
        end else if (accept && (is_cdo || (is_cxf && XFER_TRAPS) ||
                     (is_crt && I_INSTR[`SCDT_F_CPNUM] != `SCDT_CP_CTRL))) begin
          // emulate in software: one cycle, no wait
          s_nxt.und_link  = word_after(I_INSTR_ADDR);
          s_nxt.und_saved = s_r.status;
          s_nxt.status[`SCDT_F_MODE] = `SCDT_MODE_UND;
          s_nxt.trap      = 1'b1;
          s_nxt.trap_kind = scdt_pkg::TRAP_UND;
          s_nxt.pc_load   = 1'b1;
          s_nxt.pc_value  = UND_VECTOR;
        end else if (accept && is_crt) begin
          // control coprocessor reached by register transfer
          s_nxt.cp_ctrl = 1'b1;
        end else if (accept && is_cxf) begin
          // core performs the transfer itself
          s_nxt.xfer       = gen_xfer;
          s_nxt.addr_valid = 1'b1;
          s_nxt.busy       = 1'b1;
          s_nxt.phase      = scdt_pkg::PH_XFER;
        end else if (accept && is_ret) begin
          // return to caller with its status word
          s_nxt.pc_load  = 1'b1;
          s_nxt.pc_value = s_r.svc_link;
          s_nxt.status   = s_r.svc_saved;
        end
      end
      scdt_pkg::PH_SVC: begin
        // one fetch per cycle, vector taken with the last
        s_nxt.fetch = 1'b1;
        s_nxt.cnt   = s_r.cnt + 3'h1;
        if (s_r.cnt == LAST_FETCH) begin
          s_nxt.pc_load  = 1'b1;
          s_nxt.pc_value = `SCDT_VEC_SVC;
          s_nxt.busy     = 1'b0;
          s_nxt.cnt      = 3'h0;
          s_nxt.phase    = scdt_pkg::PH_IDLE;
        end
      end
      scdt_pkg::PH_XFER: begin
        if (I_MEM_ABORT) begin
          // abort keeps write-back and traps, status word unchanged
          s_nxt.base_wb    = s_r.xfer.wb_en;
          s_nxt.trap       = 1'b1;
          s_nxt.trap_kind  = scdt_pkg::TRAP_ABT;
          s_nxt.pc_load    = 1'b1;
          s_nxt.pc_value   = ABT_VECTOR;
          s_nxt.addr_valid = 1'b0;
          s_nxt.busy       = 1'b0;
          s_nxt.phase      = scdt_pkg::PH_IDLE;
        end else if (I_WORD_ACK && I_XFER_LAST) begin
          // software never asks write-back to pc base
          s_nxt.base_wb    = s_r.xfer.wb_en;
          s_nxt.addr_valid = 1'b0;
          s_nxt.busy       = 1'b0;
          s_nxt.phase      = scdt_pkg::PH_IDLE;
        end else if (I_WORD_ACK) begin
          s_nxt.xfer.addr = word_after(s_r.xfer.addr);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      s_r        <= '0;
      s_r.status <= `SCDT_STAT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_BUSY          = s_r.busy;
  assign O_FETCH         = s_r.fetch;
  assign O_PC_LOAD       = s_r.pc_load;
  assign O_PC_VALUE      = s_r.pc_value;
  assign O_STATUS        = s_r.status;
  assign O_SVC_LINK      = s_r.svc_link;
  assign O_SVC_SAVED     = s_r.svc_saved;
  assign O_UND_LINK      = s_r.und_link;
  assign O_UND_SAVED     = s_r.und_saved;
  assign O_TRAP          = s_r.trap;
  assign O_TRAP_KIND     = s_r.trap_kind;
  assign O_CP_CTRL       = s_r.cp_ctrl;
  assign O_ADDR_VALID    = s_r.addr_valid;
  assign O_ADDR          = s_r.xfer.addr;
  assign O_BASE_WB       = s_r.base_wb;
  assign O_BASE_WB_VALUE = s_r.xfer.wb_value;
  assign O_BASE_REG      = s_r.xfer.base_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  logic svc_take;
  logic cdo_take;
  logic xfer_take;
  assign svc_take = accept && is_svc && !s_r.busy;
  assign cdo_take = accept && is_cdo;
  // transfer performed by the core rather than trapped
  assign xfer_take = accept && is_cxf && !XFER_TRAPS;

  a_svc_link_save: assert property (
    svc_take |=> O_SVC_LINK == $past(I_INSTR_ADDR) + `SCDT_WORD_STEP)
    else $error("link is not the word after the call");

  a_svc_vector_status: assert property (
    svc_take |=> O_SVC_SAVED == $past(O_STATUS) ##2
    (O_PC_LOAD && O_PC_VALUE == `SCDT_VEC_SVC))
    else $error("call vector or saved status wrong");

  a_svc_fetch_cost: assert property (
    svc_take |=> (O_FETCH && !O_PC_LOAD)[*2] ##1 (O_FETCH && O_PC_LOAD)
    ##1 !O_FETCH)
    else $error("call does not take three fetches");

  a_ret_restore: assert property (
    (accept && is_ret && !is_svc) |=> O_PC_LOAD &&
    O_PC_VALUE == $past(O_SVC_LINK) && O_STATUS == $past(O_SVC_SAVED))
    else $error("return did not restore pc and status");

  a_cdo_undef: assert property (
    cdo_take |=> O_TRAP && O_TRAP_KIND == scdt_pkg::TRAP_UND &&
    !O_BUSY && O_PC_VALUE == UND_VECTOR)
    else $error("data operation did not trap at once");

  a_cond_fail_quiet: assert property (
    (I_INSTR_VALID && !I_COND_PASS && !O_BUSY) |=>
    !O_TRAP && !O_CP_CTRL && !O_ADDR_VALID && !O_FETCH)
    else $error("failed condition had an effect");

  a_ctrl_only_15: assert property (
    O_CP_CTRL |-> $past(I_INSTR[`SCDT_F_CPNUM]) == `SCDT_CP_CTRL &&
    $past(is_crt))
    else $error("transfer reached a coprocessor other than 15");

  a_und_mode_link: assert property (
    (O_TRAP && O_TRAP_KIND == scdt_pkg::TRAP_UND) |->
    O_STATUS[`SCDT_F_MODE] == `SCDT_MODE_UND &&
    O_UND_LINK == $past(I_INSTR_ADDR) + `SCDT_WORD_STEP)
    else $error("undefined trap mode or link wrong");

  a_xfer_word_step: assert property (
    (O_ADDR_VALID && I_WORD_ACK && !I_XFER_LAST && !I_MEM_ABORT) |=>
    O_ADDR_VALID && O_ADDR == $past(O_ADDR) + `SCDT_WORD_STEP)
    else $error("next word address not four higher");

  a_abort_writeback: assert property (
    (O_ADDR_VALID && I_MEM_ABORT) |=> O_TRAP &&
    O_TRAP_KIND == scdt_pkg::TRAP_ABT && O_BASE_WB == $past(s_r.xfer.wb_en)
    && $stable(O_STATUS))
    else $error("abort lost write-back or changed state");

  a_xfer_traps: assert property (
    (accept && is_cxf && XFER_TRAPS) |=> O_TRAP && !O_ADDR_VALID)
    else $error("load or store did not trap");

  // transfer addressing, checked from the instruction fields
  // pre-indexed upward with a register base: offset added before use
  a_pre_up_addr: assert property (
    (xfer_take && I_INSTR[`SCDT_B_PRE] && I_INSTR[`SCDT_B_UP] &&
     I_INSTR[`SCDT_F_RN] != `SCDT_REG_PC) |=>
    O_ADDR == $past(I_BASE_VALUE) +
    {`SCDT_OFF_PAD, $past(I_INSTR[`SCDT_F_OFF]), `SCDT_OFF_LOW})
    else $error("pre-indexed address is not base plus scaled offset");

  // post-indexed: the old base is the first address
  a_post_base_addr: assert property (
    (xfer_take && !I_INSTR[`SCDT_B_PRE] && I_INSTR[`SCDT_F_RN] != `SCDT_REG_PC) |=>
    O_ADDR == $past(I_BASE_VALUE))
    else $error("post-indexed address is not the old base");

  // downward offset lands in the write-back value
  a_down_wb_value: assert property (
    (xfer_take && !I_INSTR[`SCDT_B_UP] && I_INSTR[`SCDT_F_RN] != `SCDT_REG_PC) |=>
    O_BASE_WB_VALUE == $past(I_BASE_VALUE) -
    {`SCDT_OFF_PAD, $past(I_INSTR[`SCDT_F_OFF]), `SCDT_OFF_LOW})
    else $error("downward offset not subtracted from base");

  // pc base reads two words ahead of the instruction
  a_pc_base_ahead: assert property (
    (xfer_take && I_INSTR[`SCDT_B_PRE] && !I_INSTR[`SCDT_B_UP] &&
     I_INSTR[`SCDT_F_RN] == `SCDT_REG_PC) |=>
    O_ADDR == $past(I_INSTR_ADDR) + `SCDT_PC_AHEAD -
    {`SCDT_OFF_PAD, $past(I_INSTR[`SCDT_F_OFF]), `SCDT_OFF_LOW})
    else $error("pc base is not instruction address plus eight");

  // write-back pulses only as a transfer closes
  a_wb_at_end: assert property (
    O_BASE_WB |-> $past(O_ADDR_VALID) && !O_ADDR_VALID)
    else $error("base write-back outside the end of a transfer");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  c_return:     cover property (accept && is_ret ##1 O_PC_LOAD);
  c_svc_call:   cover property (svc_take ##3 O_PC_LOAD);
  c_cdo_trap:   cover property (cdo_take ##1 O_TRAP);
  c_multi_word: cover property (O_ADDR_VALID && I_WORD_ACK ##1 O_ADDR_VALID);
  c_abort:      cover property (O_ADDR_VALID && I_MEM_ABORT);
endmodule

// ### rtl/scdt_defs.svh
`ifndef SCDT_DEFS_SVH
`define SCDT_DEFS_SVH
// ----------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------
`define SCDT_F_CLS4    27:24
`define SCDT_F_CLS3    27:25
`define SCDT_F_CPNUM   11:8
`define SCDT_F_RN      19:16
`define SCDT_F_OFF     7:0
`define SCDT_F_BODY    27:0
`define SCDT_B_CPBIT   4
`define SCDT_B_PRE     24
`define SCDT_B_UP      23
`define SCDT_B_WB      21
`define SCDT_F_MODE    4:0
// ----------------------------------------------------------------
// class codes and fixed values
// ----------------------------------------------------------------
`define SCDT_CLS_SVC   4'hF
`define SCDT_CLS_CDO   4'hE
`define SCDT_CLS_CXF   3'h6
`define SCDT_CP_CTRL   4'hF
`define SCDT_REG_PC    4'hF
`define SCDT_RET_BODY  28'h1B0F00E
`define SCDT_MODE_SVC  5'h13
`define SCDT_MODE_UND  5'h1B
`define SCDT_STAT_RST  32'h00000013
`define SCDT_VEC_SVC   32'h00000008
`define SCDT_VEC_UND   32'h00000004
`define SCDT_VEC_ABT   32'h00000010
`define SCDT_WORD_STEP 32'h00000004
`define SCDT_PC_AHEAD  32'h00000008
`define SCDT_OFF_PAD   22'h000000
`define SCDT_OFF_LOW   2'h0
`define SCDT_SVC_FETCH 3
`endif

// ### rtl/scdt_pkg.sv
package scdt_pkg;
  // ----------------------------------------------------------------
  // sequencer phases and trap kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_SVC, PH_XFER} scdt_phase_t;
  typedef enum logic [1:0] {TRAP_UND, TRAP_SVC, TRAP_ABT} scdt_trap_t;

  // coprocessor transfer addressing result
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wb_value;
    logic        wb_en;
    logic [3:0]  base_reg;
  } scdt_xfer_t;

  // whole state of the decoder
  typedef struct packed {
    scdt_phase_t phase;
    logic [2:0]  cnt;
    logic        busy;
    logic        fetch;
    logic        pc_load;
    logic [31:0] pc_value;
    logic [31:0] status;
    logic [31:0] svc_link;
    logic [31:0] svc_saved;
    logic [31:0] und_link;
    logic [31:0] und_saved;
    logic        trap;
    scdt_trap_t  trap_kind;
    logic        cp_ctrl;
    logic        addr_valid;
    logic        base_wb;
    scdt_xfer_t  xfer;
  } scdt_core_t;
endpackage

// ### rtl/scdt_addr_gen.sv
`timescale 1ns/1ps
`include "scdt_defs.svh"
module scdt_addr_gen (
  input  wire logic [31:0]       i_instr,
  input  wire logic [31:0]       i_instr_addr,
  input  wire logic [31:0]       i_base_value,
  output scdt_pkg::scdt_xfer_t   o_xfer
);
  logic [31:0] base;
  logic [31:0] offset;
  logic [31:0] modified;

  // ----------------------------------------------------------------
  // base, scaled offset and indexing
  // ----------------------------------------------------------------
  always_comb begin
    // pc base reads two words ahead of the instruction
    base = (i_instr[`SCDT_F_RN] == `SCDT_REG_PC) ?
           i_instr_addr + `SCDT_PC_AHEAD : i_base_value;
    // unsigned word offset scaled to bytes
    offset   = {`SCDT_OFF_PAD, i_instr[`SCDT_F_OFF], `SCDT_OFF_LOW};
    modified = i_instr[`SCDT_B_UP] ? base + offset : base - offset;
    // low address bits pass unaligned
    o_xfer.addr     = i_instr[`SCDT_B_PRE] ? modified : base;
    o_xfer.wb_value = modified;
    o_xfer.wb_en    = i_instr[`SCDT_B_WB];
    o_xfer.base_reg = i_instr[`SCDT_F_RN];
  end
endmodule

// ### testbench/scdt_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory and translation unit seen by coprocessor transfers
// ----------------------------------------------------------------
module scdt_mem_model (
  input  wire logic       i_clock,
  input  wire logic       i_addr_valid,
  input  wire logic [7:0] i_words,
  input  wire logic [7:0] i_wait,
  input  wire logic [7:0] i_abort_at,
  output logic            o_word_ack,
  output logic            o_xfer_last,
  output logic            o_mem_abort
);
  int word_cnt;
  int wait_cnt;

  initial begin
    o_word_ack  = 1'b0;
    o_xfer_last = 1'b0;
    o_mem_abort = 1'b0;
  end

  // one word per acceptance after a programmable stall, abort at a chosen word
  always @(posedge i_clock) begin
    #2;
    if (i_addr_valid !== 1'b1) begin
      word_cnt    = 0; // counts restart so an aborted transfer replays alike
      wait_cnt    = 0;
      o_word_ack  = 1'b0;
      o_xfer_last = 1'b0;
      o_mem_abort = 1'b0;
    end else begin
      if (o_word_ack) begin
        word_cnt++;
        wait_cnt = 0;
      end
      o_word_ack  = 1'b0;
      o_xfer_last = 1'b0;
      if (wait_cnt < i_wait) begin
        wait_cnt++;
      end else if (i_abort_at != 8'h00 && word_cnt == i_abort_at) begin
        o_mem_abort = 1'b1;
      end else begin
        o_word_ack  = 1'b1;
        o_xfer_last = (word_cnt == i_words - 1); // the far side decides the count
      end
    end
  end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                 clock, rst_n, valid, cond, ack, last, abort;
  logic [31:0]          instr, iaddr, base, pc_value, status, svc_link, svc_saved;
  logic [31:0]          und_link, und_saved, addr, wb_value, link_copy;
  logic                 busy, fetch, pc_load, trap, cp_ctrl, a_valid, base_wb, t1_trap;
  logic [3:0]           base_reg;
  logic [7:0]           m_words, m_wait, m_abort;
  scdt_pkg::scdt_trap_t trap_kind, t1_kind;
  int                   err_total, comparisons;

  // ----------------------------------------------------------------
  // design with the transfer path, and one with transfers trapping
  // ----------------------------------------------------------------
  scdt_decode_trap #(.XFER_TRAPS(1'b0)) u_scdt_decode_trap (
    .I_CLOCK(clock), .I_RST_N(rst_n), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_INSTR_ADDR(iaddr), .I_COND_PASS(cond), .I_BASE_VALUE(base), .I_WORD_ACK(ack),
    .I_XFER_LAST(last), .I_MEM_ABORT(abort), .O_BUSY(busy), .O_FETCH(fetch),
    .O_PC_LOAD(pc_load), .O_PC_VALUE(pc_value), .O_STATUS(status), .O_SVC_LINK(svc_link),
    .O_SVC_SAVED(svc_saved), .O_UND_LINK(und_link), .O_UND_SAVED(und_saved), .O_TRAP(trap),
    .O_TRAP_KIND(trap_kind), .O_CP_CTRL(cp_ctrl), .O_ADDR_VALID(a_valid), .O_ADDR(addr),
    .O_BASE_WB(base_wb), .O_BASE_WB_VALUE(wb_value), .O_BASE_REG(base_reg));
  scdt_decode_trap u_scdt_decode_trap_xt (
    .I_CLOCK(clock), .I_RST_N(rst_n), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_INSTR_ADDR(iaddr), .I_COND_PASS(cond), .I_BASE_VALUE(base), .I_WORD_ACK(ack),
    .I_XFER_LAST(last), .I_MEM_ABORT(abort), .O_BUSY(), .O_FETCH(), .O_PC_LOAD(),
    .O_PC_VALUE(), .O_STATUS(), .O_SVC_LINK(), .O_SVC_SAVED(), .O_UND_LINK(), .O_UND_SAVED(),
    .O_TRAP(t1_trap), .O_TRAP_KIND(t1_kind), .O_CP_CTRL(), .O_ADDR_VALID(), .O_ADDR(),
    .O_BASE_WB(), .O_BASE_WB_VALUE(), .O_BASE_REG());
  scdt_mem_model u_scdt_mem_model (
    .i_clock(clock), .i_addr_valid(a_valid), .i_words(m_words), .i_wait(m_wait),
    .i_abort_at(m_abort), .o_word_ack(ack), .o_xfer_last(last), .o_mem_abort(abort));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // offer one instruction for one cycle, return in the answer cycle
  task automatic issue(input logic [31:0] w, input logic [31:0] a);
    @(posedge clock);
    #2;
    valid = 1'b1;
    instr = w;
    iaddr = a;
    @(posedge clock);
    #2;
    valid = 1'b0;
    instr = ~w;
  endtask

  task automatic und(input logic [31:0] w, input logic [31:0] a, input logic [4:0] pm);
    issue(w, a);
    chk({31'h0, trap}, 32'h1);
    chk({30'h0, trap_kind}, {30'h0, scdt_pkg::TRAP_UND});
    chk({31'h0, pc_load}, 32'h1);
    chk(und_link, a + 32'h4);
    chk({27'h0, und_saved[4:0]}, {27'h0, pm});
    chk({27'h0, status[4:0]}, 32'h1B);
    chk({31'h0, busy}, 32'h0);
  endtask

  task automatic svc(input logic [31:0] w, input logic [31:0] a, input logic [4:0] pm);
    issue(w, a);
    chk({30'h0, trap_kind}, {30'h0, scdt_pkg::TRAP_SVC});
    chk(svc_link, a + 32'h4);
    chk({27'h0, svc_saved[4:0]}, {27'h0, pm});
    chk({27'h0, status[4:0]}, 32'h13);
    for (int k = 0; k < 4; k++) begin
      chk({31'h0, fetch}, {31'h0, k < 3});
      chk({31'h0, pc_load}, {31'h0, k == 2});
      if (k == 2) chk(pc_value, 32'h8);
      @(posedge clock);
      #2;
    end
  endtask

  // coprocessor transfer: addresses per word, then write-back or abort
  task automatic xfer(input logic p, u, w, input logic [3:0] rn, input logic [7:0] off,
                      input logic [31:0] b, a, input logic [7:0] nw, wt, ab);
    logic [31:0] bv, mv, ex, a0;
    int          n;
    bv = (rn == 4'hF) ? a + 32'h8 : b;
    mv = u ? bv + {22'h0, off, 2'h0} : bv - {22'h0, off, 2'h0};
    ex = p ? mv : bv;
    a0 = ex;
    @(posedge clock);
    #2;
    m_words = nw;
    m_wait  = wt;
    m_abort = ab;
    base    = b;
    issue({4'hE, 3'h6, p, u, 1'b0, w, 1'b1, rn, 8'h01, off}, a);
    chk({31'h0, t1_trap}, 32'h1);
    chk({30'h0, t1_kind}, {30'h0, scdt_pkg::TRAP_UND});
    #1;
    for (n = 0; n < 60 && a_valid === 1'b1; n++) begin
      chk(addr, ex);
      if (ack === 1'b1) ex = ex + 32'h4;
      @(posedge clock);
      #3;
    end
    if (n == 60) begin
      err_total++;
      results();
    end
    chk(ex, a0 + {22'h0, (ab != 8'h00) ? ab : nw, 2'h0});
    chk({31'h0, base_wb}, {31'h0, w});
    chk(wb_value, mv);
    chk({28'h0, base_reg}, {28'h0, rn});
    chk({31'h0, trap}, {31'h0, ab != 8'h00});
    if (ab != 8'h00) chk(pc_value, 32'h10);
    chk({27'h0, status[4:0]}, 32'h13);
  endtask

  // ----------------------------------------------------------------
  // clock, hang guard and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    rst_n = 1'b0;
    valid = 1'b0;
    cond  = 1'b1;
    instr = 32'h0;
    iaddr = 32'h0;
    base  = 32'h0;
    m_words = 8'h01;
    m_wait  = 8'h00;
    m_abort = 8'h00;
    repeat (5) @(posedge clock);
    #2;
    rst_n = 1'b1;
    chk(status, 32'h13);
    chk({31'h0, trap}, 32'h0);
    // failing condition: nothing happens
    cond = 1'b0;
    issue(32'hEE000100, 32'h80);
    chk({31'h0, trap}, 32'h0);
    chk({27'h0, status[4:0]}, 32'h13);
    cond = 1'b1;
    und(32'hEE000100, 32'h84, 5'h13);
    und(32'hEEFFFFEF, 32'h88, 5'h1B);
    und(32'hEE100310, 32'h8C, 5'h1B);
    // register transfers to the control coprocessor are accepted
    for (int i = 0; i < 2; i++) begin
      issue(i ? 32'hEE010F30 : 32'hEE110F10, 32'h90);
      chk({31'h0, cp_ctrl}, 32'h1);
      chk({31'h0, trap}, 32'h0);
    end
    svc(32'hEF123456, 32'h200, 5'h1B);
    issue(32'hE1B0F00E, 32'h208);
    chk(pc_value, 32'h204);
    chk({27'h0, status[4:0]}, 32'h1B);
    svc(32'hEFFFFFFF, 32'h400, 5'h1B);
    // nested call from supervisor code, which keeps its own return state
    link_copy = svc_link;
    svc(32'hEF000000, 32'h600, 5'h13);
    issue(32'hE1B0F00E, 32'h608);
    chk(pc_value, 32'h604);
    chk({27'h0, status[4:0]}, 32'h13);
    chk(link_copy, 32'h404);
    xfer(1'b1, 1'b1, 1'b1, 4'h3, 8'h05, 32'h1000, 32'h500, 8'h03, 8'h00, 8'h00);
    xfer(1'b0, 1'b0, 1'b1, 4'h4, 8'h10, 32'h2003, 32'h504, 8'h02, 8'h02, 8'h00);
    xfer(1'b1, 1'b0, 1'b0, 4'hF, 8'h01, 32'h0, 32'h3000, 8'h01, 8'h00, 8'h00);
    xfer(1'b1, 1'b1, 1'b1, 4'h2, 8'hFF, 32'h4000, 32'h508, 8'h04, 8'h01, 8'h02);
    xfer(1'b1, 1'b1, 1'b1, 4'h2, 8'hFF, 32'h4000, 32'h508, 8'h04, 8'h01, 8'h00);
    results();
  end
endmodule
